// ---- include/ascs_pkg.sv ----
// shared constants for the serial conversion sequencer
package ascs_pkg;
	localparam int RES_BITS      = 12;
	localparam int CHAN_BITS     = 3;
	localparam int CTRL_BITS     = 8;
	localparam int SLOT_EDGES    = 16;
	localparam int TRACK_EDGES   = 3;
	localparam int ZERO_EDGES    = 4;
	localparam int CHAN_MSB_POS  = 5;
	localparam int CHAN_LSB_POS  = 3;
	localparam logic [4:0] CNT_RST = 5'h00;
	localparam logic [2:0] CHAN_RST = 3'h0;
	typedef enum logic [1:0] {ascs_idle, ascs_track, ascs_hold} ascs_phase_t;
endpackage

// ---- rtl/ascs_core.sv ----
// serial port and conversion sequencing of an eight-channel sampling converter
`timescale 1ns/1ps
module ascs_core
	import ascs_pkg::*;
#(
	parameter int RES_W = RES_BITS
) (
	// clock, reset, enable
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic             clk_en,
	// serial pins
	input  wire logic             cs_n_pin,
	input  wire logic             sclk_pin,
	input  wire logic             din_pin,
	output logic                  dout_o,
	output logic                  dout_oe,
	// converter side
	output logic [CHAN_BITS-1:0]  mux_chan,
	input  wire logic [RES_W-1:0] conv_code,
	output logic                  track_en,
	output logic                  hold_en,
	output logic                  power_up,
	// parallel result
	output logic [RES_W-1:0]      res_data,
	output logic [CHAN_BITS-1:0]  res_chan,
	output logic                  res_valid
);
	logic        cs_n_s;
	logic        sclk_s;
	logic        din_s;
	logic        cs_n_d_r;
	logic        sclk_d_r;
	logic [4:0]  fall_cnt_r;
	logic [4:0]  rise_cnt_r;
	logic [CTRL_BITS-1:0] ctrl_sh_r;
	logic [CHAN_BITS-1:0] next_chan_r;
	logic [CHAN_BITS-1:0] cur_chan_r;
	logic [RES_W-1:0]     res_sh_r;
	logic [RES_W-1:0]     code_hold_r;
	logic        dout_r;
	logic        sclk_fall;
	logic        sclk_rise;
	logic        frame_start;
	logic        slot_fall;
	logic        active;
	logic [4:0]  fall_nxt;
	ascs_phase_t phase;

	// pins cross into core_clk through two flops each
	ascs_sync #(.W(1), .RST_VAL(1'b1)) u_cs (.core_clk(core_clk), .nrst(nrst),
		.clk_en(clk_en), .d(cs_n_pin), .q(cs_n_s));
	ascs_sync #(.W(2), .RST_VAL(1'b0)) u_dat (.core_clk(core_clk), .nrst(nrst),
		.clk_en(clk_en), .d({sclk_pin, din_pin}), .q({sclk_s, din_s}));

	// edge detection on synchronised levels; clock gated off while deselected
	assign active      = !cs_n_s;
	assign frame_start = cs_n_d_r && !cs_n_s;
	assign sclk_fall   = active && sclk_d_r && !sclk_s && !frame_start;
	assign sclk_rise   = active && !sclk_d_r && sclk_s;
	// select falling with clock low, or together with it, is the first falling edge
	assign slot_fall   = sclk_fall || (frame_start && !sclk_s);
	assign fall_nxt    = (fall_cnt_r == 5'(SLOT_EDGES)) ? 5'h01 : fall_cnt_r + 5'h01;

	// phase: idle until first falling edge, track until the third rising edge, then hold
	always_comb begin
		if (!active || fall_cnt_r == CNT_RST)
			phase = ascs_idle;
		else if (fall_cnt_r <= 5'(ZERO_EDGES - 1) && rise_cnt_r < 5'(TRACK_EDGES))
			phase = ascs_track;
		else
			phase = ascs_hold;
	end
	assign track_en = (phase == ascs_track);
	assign hold_en  = (phase == ascs_hold);
	// powered whenever selected, except from the sixteenth falling edge to the next slot
	assign power_up = active && fall_cnt_r != 5'(SLOT_EDGES);
	assign mux_chan = cur_chan_r;
	assign dout_oe  = !cs_n_pin;
	assign dout_o   = dout_r;

	// edge history
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cs_n_d_r <= 1'b1;
			sclk_d_r <= 1'b0;
		end else if (clk_en) begin
			cs_n_d_r <= cs_n_s;
			sclk_d_r <= sclk_s;
		end
	end

	// falling-edge counter; wraps every slot for continuous mode
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			fall_cnt_r <= CNT_RST;
		else if (clk_en) begin
			if (!active)
				fall_cnt_r <= CNT_RST;
			else if (slot_fall)
				fall_cnt_r <= fall_nxt;
		end
	end

	// rising-edge counter; restarts at the first falling edge of a slot
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			rise_cnt_r <= CNT_RST;
		else if (clk_en) begin
			if (!active || (slot_fall && fall_nxt == 5'h01))
				rise_cnt_r <= CNT_RST;
			else if (sclk_rise && rise_cnt_r != 5'(SLOT_EDGES))
				rise_cnt_r <= rise_cnt_r + 5'h01;
		end
	end

	// control word capture on first eight rising edges of each slot
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			ctrl_sh_r <= '0;
		else if (clk_en && sclk_rise && rise_cnt_r < 5'(CTRL_BITS))
			ctrl_sh_r <= {ctrl_sh_r[CTRL_BITS-2:0], din_s};
	end

	// channel held for the next conversion; reset value stands in for the unknown
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			next_chan_r <= CHAN_RST;
		else if (clk_en && sclk_rise && rise_cnt_r == 5'(CTRL_BITS - 1))
			next_chan_r <= {ctrl_sh_r[CHAN_MSB_POS-1:CHAN_LSB_POS-1]};
	end

	// result shift and output; sampled code is straight binary already
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cur_chan_r <= CHAN_RST;
			res_sh_r   <= '0;
			dout_r     <= 1'b0;
		end else if (clk_en) begin
			if (slot_fall && fall_nxt == 5'h01)
				cur_chan_r <= next_chan_r;
			if (slot_fall && fall_nxt == 5'(ZERO_EDGES)) begin
				res_sh_r <= conv_code;
				dout_r   <= 1'b0;
			end else if (slot_fall && fall_nxt > 5'(ZERO_EDGES)) begin
				dout_r   <= res_sh_r[RES_W-1];
				res_sh_r <= {res_sh_r[RES_W-2:0], 1'b0};
			end else if (slot_fall)
				dout_r <= 1'b0;
		end
	end

	// parallel word after the sixteenth falling edge; the code is kept aside from the
	// fourth falling edge so that data and channel always change together
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			code_hold_r <= '0;
			res_data    <= '0;
			res_chan    <= CHAN_RST;
			res_valid   <= 1'b0;
		end else if (clk_en) begin
			res_valid <= slot_fall && fall_nxt == 5'(SLOT_EDGES);
			if (slot_fall && fall_nxt == 5'(ZERO_EDGES))
				code_hold_r <= conv_code;
			if (slot_fall && fall_nxt == 5'(SLOT_EDGES)) begin
				res_data <= code_hold_r;
				res_chan <= cur_chan_r;
			end
		end
	end

	// output enable follows chip select with no clock
	a_oe_follows_cs: assert property (@(posedge core_clk) disable iff (!nrst)
		dout_oe == !cs_n_pin) else $error("dout enable mismatch");
	// falling-edge counter stays cleared while deselected
	a_idle_cleared: assert property (@(posedge core_clk) disable iff (!nrst)
		clk_en && cs_n_s |=> fall_cnt_r == CNT_RST) else $error("count not cleared");
	// falling edges 1 to 4 drive zero
	a_lead_zeros: assert property (@(posedge core_clk) disable iff (!nrst)
		clk_en && slot_fall && fall_nxt <= 5'(ZERO_EDGES) |=> !dout_r) else $error("lead not zero");
	// valid is a single pulse
	a_valid_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
		res_valid && clk_en |=> !res_valid) else $error("valid too long");
	// valid only after sixteenth falling edge
	a_valid_cause: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(res_valid) |-> $past(fall_nxt) == 5'(SLOT_EDGES)) else $error("valid stray");
	// channel taken at eighth rising edge
	a_chan_load: assert property (@(posedge core_clk) disable iff (!nrst)
		clk_en && sclk_rise && rise_cnt_r == 5'(CTRL_BITS - 1) |=>
		next_chan_r == $past(ctrl_sh_r[4:2])) else $error("channel not loaded");
	// select low with clock low starts the slot at once
	a_low_start: assert property (@(posedge core_clk) disable iff (!nrst)
		clk_en && frame_start && !sclk_s |=> fall_cnt_r == 5'h01) else $error("no start");
	// hold never coincides with track
	a_phase_excl: assert property (@(posedge core_clk) disable iff (!nrst)
		!(track_en && hold_en)) else $error("track and hold together");
	// slot end and end of tracking, the two steps the checks below start from
	sequence s_last_fall;
		clk_en && slot_fall && fall_nxt == 5'(SLOT_EDGES);
	endsequence
	sequence s_third_rise;
		clk_en && sclk_rise && rise_cnt_r == 5'(TRACK_EDGES - 1) && fall_cnt_r != CNT_RST;
	endsequence
	// powered down from the sixteenth falling edge until the next slot starts
	a_gap_power: assert property (@(posedge core_clk) disable iff (!nrst)
		s_last_fall |=> !power_up) else $error("powered in slot gap");
	// hold begins at the third rising edge, two and a half serial clock cycles into tracking
	a_track_ends: assert property (@(posedge core_clk) disable iff (!nrst)
		s_third_rise |=> hold_en && !track_en) else $error("track too long");
endmodule

// ---- rtl/ascs_sync.sv ----
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module ascs_sync #(
	parameter int        W       = 1,
	parameter logic [0:0] RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic         clk_en,
	// data
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= {W{RST_VAL}};
			q      <= {W{RST_VAL}};
		end else if (clk_en) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ---- test/adc_serial_conversion_sequencer_tb_top.sv ----
// self-checking bench for the serial conversion sequencer
`timescale 1ns/1ps
module adc_serial_conversion_sequencer_tb_top;
	import ascs_pkg::*;
	logic                 core_clk = 1'b0;
	logic                 nrst = 1'b0;
	logic                 cs_n, sclk, din, dout, dout_oe;
	logic                 track_en, hold_en, power_up, res_valid;
	logic [CHAN_BITS-1:0] mux_chan, res_chan;
	logic [RES_BITS-1:0]  res_data, conv_code = 12'h000;
	int                   fails = 0;
	int                   n_compared = 0;
	int                   n_valid = 0;
	int                   n_track = 0;
	int                   n_hold = 0;
	int                   n_power = 0;
	// 20 MHz core clock
	always #25 core_clk = ~core_clk;
	// analog stand-in: each channel gives a distinct code
	function automatic logic [11:0] code_of(input logic [2:0] c);
		return {c, ~c, 6'h2d};
	endfunction
	always @(negedge core_clk) conv_code <= code_of(mux_chan);
	// count result pulses and phase cycles between edges, where outputs have settled
	always @(negedge core_clk) begin
		if (res_valid === 1'b1) n_valid++;
		if (track_en === 1'b1) n_track++;
		if (hold_en === 1'b1) n_hold++;
		if (power_up === 1'b1) n_power++;
	end
	ascs_core dut (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .cs_n_pin(cs_n),
		.sclk_pin(sclk), .din_pin(din), .dout_o(dout), .dout_oe(dout_oe),
		.mux_chan(mux_chan), .conv_code(conv_code), .track_en(track_en), .hold_en(hold_en),
		.power_up(power_up), .res_data(res_data), .res_chan(res_chan), .res_valid(res_valid));
	ascs_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// four back-to-back slots, ignored control bits set; slot 0 is the dummy
	task automatic sc_stream();
		logic [7:0] w [];
		logic [2:0] ch [3];
		int         v0, t0, h0, p0;
		w = '{8'hd8, 8'h2f, 8'h38, 8'h07};
		ch = '{3'h3, 3'h5, 3'h7};
		v0 = n_valid;
		t0 = n_track;
		h0 = n_hold;
		p0 = n_power;
		host.rx_q.delete();
		host.frame(w, 0);
		repeat (8) @(negedge core_clk);
		for (int i = 0; i < 3; i++) begin
			chk(host.rx_q[i + 1], {4'h0, code_of(ch[i])});
		end
		chk(16'(n_valid - v0), 16'h0004);
		chk({1'b0, res_chan, res_data}, {1'b0, 3'h7, code_of(3'h7)});
		chk({15'h0, power_up}, 16'h0000);
		// sclk period is 8 core cycles: track runs 2.5 periods, 20 cycles per slot
		chk(16'(n_track - t0), 16'h0050);
		// 512 selected cycles, one idle before the first falling edge, rest is hold
		chk(16'(n_hold - h0), 16'h01af);
		// unpowered 8 cycles in each slot gap and 7 after the last slot
		chk(16'(n_power - p0), 16'h01e1);
	endtask
	// two-slot frame entered in a given way
	task automatic sc_entry(input int mode, input logic [2:0] prev, a, b);
		logic [7:0] w [];
		w = '{{2'h0, a, 3'h0}, {2'h0, b, 3'h0}};
		host.rx_q.delete();
		host.frame(w, mode);
		chk(host.rx_q[0], {4'h0, code_of(prev)});
		chk(host.rx_q[1], {4'h0, code_of(a)});
		chk({15'h0, host.oe_ok}, 16'h0001);
	endtask
	// stray clocking while deselected must not shift the slot count
	task automatic sc_gated();
		int v0;
		v0 = n_valid;
		host.stray(18);
		chk(16'(n_valid - v0), 16'h0000);
		chk({15'h0, dout_oe}, 16'h0000);
		sc_entry(0, 3'h4, 3'h3, 3'h5);
	endtask
	// hang guard
	initial begin
		#500000;
		fails++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk) nrst = 1'b1;
		repeat (4) @(negedge core_clk);
		sc_stream();
		sc_entry(1, 3'h0, 3'h6, 3'h2);
		sc_entry(2, 3'h2, 3'h1, 3'h4);
		sc_gated();
		summarize();
	end
endmodule

// ---- test/ascs_host_model.sv ----
// host-side serial controller model that frames conversions
`timescale 1ns/1ps
module ascs_host_model (
	// edge alignment
	input  wire logic core_clk,
	// serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	logic [15:0] rx_q [$];
	logic        oe_ok;
	// idle: deselected, clock still
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	// mode 0 select falls with clock low, 1 with clock high, 2 both together
	task automatic frame(input logic [7:0] ctrl [], input int mode);
		logic [15:0] w;
		@(negedge core_clk);
		sclk = (mode != 0);
		#200 cs_n = 1'b0;
		if (mode == 2) sclk = 1'b0;
		if (mode == 1) #200 sclk = 1'b0;
		oe_ok = 1'b1;
		foreach (ctrl[s]) begin
			for (int b = 0; b < 16; b++) begin
				// past bit 8 the line keeps changing so a late sample shows up
				din = (b < 8) ? ctrl[s][7 - b] : ~din;
				#200 sclk = 1'b1;
				#150 w = {w[14:0], dout};
				oe_ok &= dout_oe;
				#50;
				if (b < 15 || s < ctrl.size() - 1) sclk = 1'b0;
			end
			rx_q.push_back(w);
		end
		cs_n = 1'b1;
	endtask
	// clock edges while deselected, which the sequencer must ignore
	task automatic stray(input int n);
		@(negedge core_clk);
		repeat (n) #200 sclk = ~sclk;
	endtask
endmodule
